// file: kms_regs.svh
// Purpose: constants for the key matrix scanner
// Assumes: 200 MHz system clock, scan tick from the 128 kHz clock rate
// Notes: only the tick count is derived from the clock rates by an expression
`ifndef KMS_REGS_SVH
`define KMS_REGS_SVH
`define KMS_MAX_ROWS 8
`define KMS_MAX_COLS 20
`define KMS_MAX_KEYS 160
`define KMS_BUF_DEPTH 16
`define KMS_CLK_HZ 200000000
`define KMS_SCAN_HZ 128000
// cycles of the system clock per scan position (rounded down)
`define KMS_TICK_CYC (`KMS_CLK_HZ / `KMS_SCAN_HZ)
`define KMS_DEB_COUNT 4
`define KMS_ROWS_RST 8'h08
`define KMS_COLS_RST 8'h14
`endif

// file: kms_pkg.sv
// Purpose: types for the key matrix scanner
// Assumes: nothing
// Notes: state names only, codes left to the tool
package kms_pkg;
   typedef enum logic [1:0] {
      KMS_IDLE,
      KMS_SCAN,
      KMS_SCAN_END
   } kms_state_t;
endpackage

// file: kms_key_buf.sv
// Purpose: 16-entry key code buffer for the scanner
// Assumes: write and read pulses from the same clock
// Notes: overflow drops the new code and raises a sticky flag
`timescale 1ns/1ps
module kms_key_buf #(
   parameter int DEPTH = 16
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_wr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_rd,
   input wire logic i_clr_ovf,
   output logic [7:0] o_rd_data,
   output logic [4:0] o_count,
   output logic o_ovf
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || DEPTH > 16 || (1 << AW) != DEPTH)
         $error("kms_key_buf: DEPTH must be a power of two, 2..16");
   end
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [4:0] cnt;
      logic ovf;
   } kms_buf_st_t;
   kms_buf_st_t st_reg, st_next;
   logic [7:0] mem [DEPTH];
   logic full, empty, do_wr, do_rd;
   assign full = (st_reg.cnt == 5'(DEPTH));
   assign empty = (st_reg.cnt == 5'h00);
   assign do_rd = i_rd && !empty;
   assign do_wr = i_wr && (!full || do_rd);
   // pointers, count and overflow; a set of ovf beats its clear
   always_comb begin
      st_next = st_reg;
      if (do_wr)
         st_next.wp = st_reg.wp + 1'b1;
      if (do_rd)
         st_next.rp = st_reg.rp + 1'b1;
      if (do_wr && !do_rd)
         st_next.cnt = st_reg.cnt + 5'h01;
      else if (do_rd && !do_wr)
         st_next.cnt = st_reg.cnt - 5'h01;
      if (i_clr_ovf)
         st_next.ovf = 1'b0;
      if (i_wr && !do_wr)
         st_next.ovf = 1'b1;
   end
   always_ff @(posedge i_clk) begin
      if (i_rst)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end
   // storage kept until read; no reset needed on the array
   always_ff @(posedge i_clk) begin
      if (do_wr)
         mem[st_reg.wp] <= i_wr_data;
   end
   assign o_rd_data = empty ? 8'h00 : mem[st_reg.rp];
   assign o_count = st_reg.cnt;
   assign o_ovf = st_reg.ovf;
endmodule

// file: kms_scanner.sv
// Purpose: autonomous 8 x 20 key matrix scanner with key code buffer
// Assumes: rows pulled down, a pressed key lifts its row to its column
// Notes: processor polls status and pops codes through plain ports
//
// Contract
// - idle drives every column output high.
// - row change in idle with enable high raises clock request and enters scan.
// - idle clears row-hit register and key index to zero.
// - row counter runs 0..rows-1, wraps, then column counter advances.
// - both counters at terminal value moves scan to scan-end.
// - key index advances with every scanned matrix position.
// - non-modifier key index goes into the key code buffer.
// - column with two or more hits ORs its rows into row-hit.
// - key in a row already set in row-hit sets ghost status bit.
// - scan-end rescans if keys found and enabled, else idle and drop clock request.
// - disabled scanner never asserts its clock request.
// - enabled scanner may drop request, reasserts it on keypress.
// - columns configurable 1 to 20, rows 1 to 8.
// - at most 160 positions, visited one after another.
// - key codes stored in a 16-byte buffer.
// - buffered codes kept until read; overflow drops the new code.
// - any number of keys; ghosts lock out the ambiguous keys.
// - a new key reports only once the shared pass counter deb reaches DEB_COUNT-1; stage agreement filters only the idle wake-up.
// - at 128 kHz a full matrix pass takes about 1.2 ms.
`timescale 1ns/1ps
`include "kms_regs.svh"
module kms_scanner #(
   parameter int ROWS_MAX = `KMS_MAX_ROWS,
   parameter int COLS_MAX = `KMS_MAX_COLS,
   parameter int BUF_DEPTH = `KMS_BUF_DEPTH,
   parameter int TICK_CYC = `KMS_TICK_CYC,
   parameter int DEB_COUNT = `KMS_DEB_COUNT
) (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_ENABLE,
   input wire logic [7:0] I_NUM_ROWS,
   input wire logic [7:0] I_NUM_COLS,
   input wire logic [ROWS_MAX-1:0] I_ROW,
   input wire logic [COLS_MAX-1:0] I_MOD_MASK_COL,
   input wire logic [ROWS_MAX-1:0] I_MOD_MASK_ROW,
   input wire logic I_POP,
   input wire logic I_CLR_STATUS,
   output logic [COLS_MAX-1:0] O_COL,
   output logic O_CLK_REQ,
   output logic [7:0] O_KEY_CODE,
   output logic O_KEY_VALID,
   output logic [4:0] O_KEY_COUNT,
   output logic O_GHOST,
   output logic O_OVERFLOW,
   output logic O_MOD_HIT,
   output logic O_SCANNING
);
   initial begin
      if (ROWS_MAX < 1 || ROWS_MAX > 8 || COLS_MAX < 1 || COLS_MAX > 20)
         $error("kms_scanner: matrix must fit 8 rows by 20 columns");
      // a tick no longer than the three sync flops samples the old column
      if (TICK_CYC < 4 || TICK_CYC > 65536 ||
          DEB_COUNT < 1 || DEB_COUNT > 15)
         $error("kms_scanner: bad tick or debounce count");
   end

   // row pins: three flops, a change counts when stages two and three agree
   logic [ROWS_MAX-1:0] row_s1_reg, row_s2_reg, row_s3_reg;
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         row_s1_reg <= '0; // idle level of a pulled-down row
         row_s2_reg <= '0;
         row_s3_reg <= '0;
      end else begin
         row_s1_reg <= I_ROW;
         row_s2_reg <= row_s1_reg;
         row_s3_reg <= row_s2_reg;
      end
   end

   typedef struct packed {
      kms_pkg::kms_state_t st;
      logic [ROWS_MAX-1:0] row_stable;
      logic [15:0] tick;
      logic [2:0] row;
      logic [4:0] col;
      logic [7:0] key_idx;
      logic [7:0] row_hit;
      logic [ROWS_MAX-1:0] col_hits;
      logic found;
      logic [COLS_MAX-1:0] col_out;
      logic clk_req;
      logic ghost;
      logic mod_hit;
      logic scanning;
      logic [3:0] deb;
      logic [COLS_MAX-1:0][ROWS_MAX-1:0] pressed;
      logic [COLS_MAX-1:0][ROWS_MAX-1:0] pressed_prev;
   } kms_st_t;
   kms_st_t st_reg, st_next;

   // clamp the programmed sizes to what the matrix supports
   logic [2:0] last_row;
   logic [4:0] last_col;
   always_comb begin
      if (I_NUM_ROWS == 8'h00)
         last_row = 3'h0;
      else if (I_NUM_ROWS > 8'(ROWS_MAX))
         last_row = 3'(ROWS_MAX - 1);
      else
         last_row = 3'(I_NUM_ROWS - 8'h01);
      if (I_NUM_COLS == 8'h00)
         last_col = 5'h00;
      else if (I_NUM_COLS > 8'(COLS_MAX))
         last_col = 5'(COLS_MAX - 1);
      else
         last_col = 5'(I_NUM_COLS - 8'h01);
   end

   // buffer write request built in the main process
   logic buf_wr;
   logic [7:0] buf_data;
   logic buf_ovf;
   logic [7:0] buf_rd_data;
   logic [4:0] buf_count;
   logic key_seen, tick_done, row_changed, key_new, is_mod;
   logic [ROWS_MAX-1:0] hits_now;
   int unsigned n_hits;

   always_comb begin
      st_next = st_reg;
      buf_wr = 1'b0;
      buf_data = st_reg.key_idx;
      tick_done = (st_reg.tick == 16'(TICK_CYC - 1));
      row_changed = (row_s2_reg == row_s3_reg) &&
                    (row_s3_reg != st_reg.row_stable);
      key_seen = row_s3_reg[st_reg.row];
      key_new = 1'b0;
      is_mod = I_MOD_MASK_COL[st_reg.col] && I_MOD_MASK_ROW[st_reg.row];
      hits_now = st_reg.col_hits;
      n_hits = 0;
      if (row_s2_reg == row_s3_reg)
         st_next.row_stable = row_s3_reg;
      if (I_CLR_STATUS) begin
         st_next.ghost = 1'b0;
         st_next.mod_hit = 1'b0;
      end
      unique case (st_reg.st)
         kms_pkg::KMS_IDLE: begin
            st_next.col_out = '1;
            st_next.row_hit = 8'h00;
            st_next.key_idx = 8'h00;
            st_next.row = 3'h0;
            st_next.col = 5'h00;
            st_next.tick = 16'h0000;
            st_next.col_hits = '0;
            st_next.found = 1'b0;
            st_next.deb = 4'h0;
            st_next.clk_req = 1'b0;
            // an aborted pass must not leave keys marked as held
            st_next.pressed = '0;
            st_next.pressed_prev = '0;
            if (I_ENABLE && row_changed) begin
               st_next.clk_req = 1'b1;
               st_next.st = kms_pkg::KMS_SCAN;
               st_next.col_out = COLS_MAX'(1);
            end
         end
         kms_pkg::KMS_SCAN: begin
            st_next.tick = tick_done ? 16'h0000 : st_reg.tick + 16'h0001;
            if (tick_done) begin
               // one position per tick: 160 ticks of 128 kHz, about 1.2 ms
               st_next.key_idx = st_reg.key_idx + 8'h01;
               if (key_seen) begin
                  hits_now[st_reg.row] = 1'b1;
                  st_next.found = 1'b1;
                  st_next.pressed[st_reg.col][st_reg.row] = 1'b1;
                  if (st_reg.row_hit[st_reg.row])
                     st_next.ghost = 1'b1;
                  key_new = !st_reg.pressed_prev[st_reg.col][st_reg.row];
               end
               st_next.col_hits = hits_now;
               // report only once debounced and not in a ghosted row
               if (key_new && st_reg.deb >= 4'(DEB_COUNT - 1) &&
                   !st_reg.row_hit[st_reg.row]) begin
                  if (is_mod)
                     st_next.mod_hit = 1'b1;
                  else
                     buf_wr = 1'b1;
               end
               if (st_reg.row == last_row) begin
                  st_next.row = 3'h0;
                  for (int i = 0; i < ROWS_MAX; i++)
                     n_hits = n_hits + 32'(hits_now[i]);
                  if (n_hits >= 2)
                     st_next.row_hit = st_reg.row_hit |
                        8'(row_s3_reg);
                  st_next.col_hits = '0;
                  if (st_reg.col == last_col) begin
                     st_next.st = kms_pkg::KMS_SCAN_END;
                     st_next.col_out = '1;
                  end else begin
                     st_next.col = st_reg.col + 5'h01;
                     st_next.col_out = COLS_MAX'(1) <<
                        (st_reg.col + 5'h01);
                  end
               end else begin
                  st_next.row = st_reg.row + 3'h1;
               end
            end
            if (!I_ENABLE) begin
               st_next.st = kms_pkg::KMS_IDLE;
               st_next.clk_req = 1'b0;
               st_next.col_out = '1;
            end
         end
         kms_pkg::KMS_SCAN_END: begin
            // a key held across passes counts up the debounce window
            st_next.pressed_prev = st_reg.pressed;
            st_next.pressed = '0;
            st_next.row = 3'h0;
            st_next.col = 5'h00;
            st_next.key_idx = 8'h00;
            st_next.row_hit = 8'h00;
            st_next.tick = 16'h0000;
            if (st_reg.found && I_ENABLE) begin
               st_next.st = kms_pkg::KMS_SCAN;
               st_next.col_out = COLS_MAX'(1);
               if (st_reg.deb < 4'(DEB_COUNT - 1))
                  st_next.deb = st_reg.deb + 4'h1;
            end else begin
               st_next.st = kms_pkg::KMS_IDLE;
               st_next.clk_req = 1'b0;
               st_next.pressed_prev = '0;
            end
            st_next.found = 1'b0;
         end
      endcase
      // registered copy keeps the scanning output straight off a flop
      st_next.scanning = (st_next.st != kms_pkg::KMS_IDLE);
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         st_reg <= '0;
         st_reg.st <= kms_pkg::KMS_IDLE;
         st_reg.col_out <= '1;
      end else begin
         st_reg <= st_next;
      end
   end

   kms_key_buf #(
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_wr(buf_wr),
      .i_wr_data(buf_data),
      .i_rd(I_POP),
      .i_clr_ovf(I_CLR_STATUS),
      .o_rd_data(buf_rd_data),
      .o_count(buf_count),
      .o_ovf(buf_ovf)
   );

   // status is polled by the processor, so register everything out
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_KEY_CODE <= 8'h00;
         O_KEY_VALID <= 1'b0;
         O_KEY_COUNT <= 5'h00;
         O_OVERFLOW <= 1'b0;
      end else begin
         O_KEY_CODE <= buf_rd_data;
         O_KEY_VALID <= (buf_count != 5'h00);
         O_KEY_COUNT <= buf_count;
         O_OVERFLOW <= buf_ovf;
      end
   end
   assign O_COL = st_reg.col_out;
   assign O_CLK_REQ = st_reg.clk_req;
   assign O_GHOST = st_reg.ghost;
   assign O_MOD_HIT = st_reg.mod_hit;
   assign O_SCANNING = st_reg.scanning;
endmodule

// file: kms_sva.sv
// Purpose: port assertions for the key matrix scanner
// Assumes: one clock, synchronous active-high reset
// Notes: buffer outputs lag the buffer by one cycle
`timescale 1ns/1ps
module kms_sva #(
   parameter int COLS_MAX = 20
) (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_ENABLE,
   input wire logic I_POP,
   input wire logic I_CLR_STATUS,
   input wire logic [COLS_MAX-1:0] O_COL,
   input wire logic O_CLK_REQ,
   input wire logic O_KEY_VALID,
   input wire logic [4:0] O_KEY_COUNT,
   input wire logic O_GHOST,
   input wire logic O_OVERFLOW,
   input wire logic O_SCANNING
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   // leaving idle for the first scan position
   sequence s_scan_start;
      !O_SCANNING ##1 O_SCANNING;
   endsequence
   a_idle_cols_high: assert property (!O_SCANNING |-> &O_COL)
      else $error("columns not all high in idle");
   a_scan_start: assert property (
      s_scan_start |-> O_CLK_REQ && O_COL == COLS_MAX'(1))
      else $error("scan entered without request or column zero");
   a_idle_no_req: assert property (!O_SCANNING |-> !O_CLK_REQ)
      else $error("clock request held in idle");
   a_off_no_req: assert property (!I_ENABLE [*2] |-> !O_CLK_REQ)
      else $error("clock request while disabled");
   a_one_col_high: assert property (
      O_SCANNING && !(&O_COL) |-> $onehot(O_COL))
      else $error("not exactly one column driven high");
   a_count_max: assert property (O_KEY_COUNT <= 5'h10)
      else $error("buffer count above capacity");
   a_valid_count: assert property (
      O_KEY_VALID == (O_KEY_COUNT != 5'h00))
      else $error("valid flag disagrees with count");
   a_count_hold: assert property (
      (!O_SCANNING && !I_POP) [*3] |-> $stable(O_KEY_COUNT))
      else $error("buffer count moved without pop or scan");
   // the overflow output lags its clear by one extra cycle
   a_ovf_sticky: assert property (
      O_OVERFLOW && !I_CLR_STATUS && !$past(I_CLR_STATUS) |=> O_OVERFLOW)
      else $error("overflow flag dropped without clear");
   a_ghost_sticky: assert property (
      O_GHOST && !I_CLR_STATUS |=> O_GHOST)
      else $error("ghost flag dropped without clear");
endmodule

// file: kms_matrix.sv
// Purpose: key switch matrix seen from the scanner pins
// Assumes: rows pulled down, a closed switch ties its row to its column
// Notes: key at row r, column c is bit c*ROWS_MAX+r of the press map
`timescale 1ns/1ps
module kms_matrix #(
   parameter int ROWS_MAX = 8,
   parameter int COLS_MAX = 20
) (
   input wire logic [COLS_MAX-1:0] i_col,
   input wire logic [ROWS_MAX*COLS_MAX-1:0] i_keys,
   output logic [ROWS_MAX-1:0] o_row
);
   // pull-downs win unless a closed key meets a high column, so a row
   // never shows a stale level once its column is released
   always_comb begin
      o_row = '0;
      for (int c = 0; c < COLS_MAX; c++) begin
         for (int r = 0; r < ROWS_MAX; r++) begin
            if (i_keys[c*ROWS_MAX+r] && i_col[c]) begin
               o_row[r] = 1'b1;
            end
         end
      end
   end
endmodule

// file: testbench.sv
// Purpose: self-checking bench for the key matrix scanner
// Assumes: tick of 4 cycles and single-pass debounce to keep runs short
// Notes: keys are pressed through the matrix model
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic en = 1'b1;
   logic [7:0] nrows = 8'h02;
   logic [7:0] ncols = 8'h03;
   logic [159:0] keys = '0;
   logic [19:0] mcol = 20'h00000;
   logic [7:0] mrow = 8'h00;
   logic pop = 1'b0;
   logic clr = 1'b0;
   logic [7:0] row, code;
   logic [19:0] col;
   logic [4:0] cnt;
   logic req, kvalid, ghost, ovf, mod, scan;
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   always #2.5 clk = ~clk;
   kms_scanner #(.TICK_CYC(4), .DEB_COUNT(1)) u_kms_scanner (
      .I_CLK(clk), .I_RST(rst), .I_ENABLE(en), .I_NUM_ROWS(nrows),
      .I_NUM_COLS(ncols), .I_ROW(row), .I_MOD_MASK_COL(mcol),
      .I_MOD_MASK_ROW(mrow), .I_POP(pop), .I_CLR_STATUS(clr),
      .O_COL(col), .O_CLK_REQ(req), .O_KEY_CODE(code),
      .O_KEY_VALID(kvalid), .O_KEY_COUNT(cnt), .O_GHOST(ghost),
      .O_OVERFLOW(ovf), .O_MOD_HIT(mod), .O_SCANNING(scan));
   kms_matrix u_kms_matrix (.i_col(col), .i_keys(keys), .o_row(row));
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done();
      if (fail_count == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // one-cycle pulses, then let the lagging outputs land
   task automatic pulse(input bit is_pop);
      @(posedge clk) if (is_pop) pop <= 1'b1; else clr <= 1'b1;
      @(posedge clk) {pop, clr} <= 2'b00;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic wait_idle();
      @(negedge clk);
      while (scan !== 1'b0) @(negedge clk);
   endtask
   // a hang is cut short here; counted as a mismatch
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         test_done();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("cols idle", {7'h00, &col}, 8'h01);
      chk("req idle", {7'h00, req}, 8'h00);
      // single key, row 1 column 2 of a 2 x 3 matrix
      @(posedge clk) keys[17] <= 1'b1;
      @(negedge clk);
      while (cnt !== 5'h01) @(negedge clk);
      chk("key code", code, 8'h05);
      chk("req scan", {7'h00, req}, 8'h01);
      pulse(1'b1);
      chk("count popped", {3'h0, cnt}, 8'h00);
      @(posedge clk) keys[17] <= 1'b0;
      wait_idle();
      chk("req dropped", {7'h00, req}, 8'h00);
      // modifier position goes to status, not the buffer
      @(posedge clk) {mcol[0], mrow[0], keys[0]} <= 3'h7;
      @(negedge clk);
      while (mod !== 1'b1) @(negedge clk);
      chk("mod count", {3'h0, cnt}, 8'h00);
      chk("req rearm", {7'h00, req}, 8'h01);
      @(posedge clk) {mcol[0], mrow[0], keys[0]} <= 3'h0;
      wait_idle();
      pulse(1'b0);
      chk("mod cleared", {7'h00, mod}, 8'h00);
      // two hits in column 0, then row 0 again in column 1
      @(posedge clk) {keys[8], keys[1], keys[0]} <= 3'h7;
      @(negedge clk);
      while (ghost !== 1'b1) @(negedge clk);
      chk("ghost codes", {3'h0, cnt}, 8'h02);
      @(posedge clk) keys <= '0;
      wait_idle();
      while (kvalid === 1'b1) pulse(1'b1);
      pulse(1'b0);
      chk("ghost cleared", {7'h00, ghost}, 8'h00);
      // 17 single-hit columns overrun the 16-entry buffer
      @(posedge clk) begin
         nrows <= 8'h01;
         ncols <= 8'h11;
         for (int c = 0; c < 17; c++) keys[c*8] <= 1'b1;
      end
      @(negedge clk);
      while (ovf !== 1'b1) @(negedge clk);
      chk("full count", {3'h0, cnt}, 8'h10);
      @(posedge clk) en <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("req disabled", {7'h00, req}, 8'h00);
      chk("ovf kept", {7'h00, ovf}, 8'h01);
      for (int i = 0; i < 16; i++) begin
         chk("fifo code", code, i[7:0]);
         pulse(1'b1);
      end
      chk("drained", {7'h00, kvalid}, 8'h00);
      test_done();
   end
endmodule
bind kms_scanner kms_sva #(.COLS_MAX(COLS_MAX)) u_kms_sva (
   .I_CLK(I_CLK), .I_RST(I_RST), .I_ENABLE(I_ENABLE), .I_POP(I_POP),
   .I_CLR_STATUS(I_CLR_STATUS), .O_COL(O_COL), .O_CLK_REQ(O_CLK_REQ),
   .O_KEY_VALID(O_KEY_VALID), .O_KEY_COUNT(O_KEY_COUNT),
   .O_GHOST(O_GHOST), .O_OVERFLOW(O_OVERFLOW), .O_SCANNING(O_SCANNING));
